// >>> verilog/ccos_pkg.sv
// Constants, frequency table and types shared by the oscillator select block.
package ccos_pkg;
  localparam int unsigned      SYS_CLK_PERIOD_NS = 100;
  localparam int unsigned      SYS_CLK_KHZ       = 1000000 / SYS_CLK_PERIOD_NS;
  localparam int unsigned      ACC_W             = 24;
  localparam int unsigned      SEL_W             = 5;
  localparam int unsigned      CFG_BITS          = 11;
  localparam int unsigned      CNT_W             = 4;
  localparam int unsigned      FLD_MCLK_LSB      = 0;
  localparam int unsigned      FLD_OSC_LSB       = 5;
  localparam int unsigned      FLD_ROUTE_BIT     = 10;
  localparam logic [SEL_W-1:0] SEL_OSC_DEFAULT   = 5'h00;
  localparam logic [SEL_W-1:0] SEL_MCLK_DEFAULT  = 5'h01;
  localparam logic [SEL_W-1:0] SEL_OSC_ONLY_LO   = 5'h0f;
  localparam logic [SEL_W-1:0] SEL_MAX           = 5'h10;
  localparam logic [CNT_W-1:0] CNT_LAST          = 4'ha;
  localparam logic [CNT_W-1:0] CNT_ZERO          = 4'h0;
  localparam logic [ACC_W-1:0] ACC_ZERO          = 24'h00_0000;
  localparam logic [ACC_W-1:0] INC_LIMIT         = 24'h80_0000;

  typedef enum logic [2:0]
  {
    PH_DEFAULT  = 3'b001,
    PH_SELECTED = 3'b010,
    PH_USER     = 3'b100
  } ccos_phase_t;

  // Table entries in kHz, index order as selected by the clock configuration bits.
  function automatic int unsigned ccos_khz(input logic [SEL_W-1:0] sel);
    case (sel)
      5'h00:   ccos_khz = 2500;
      5'h01:   ccos_khz = 3100;
      5'h02:   ccos_khz = 4300;
      5'h03:   ccos_khz = 5400;
      5'h04:   ccos_khz = 6900;
      5'h05:   ccos_khz = 8100;
      5'h06:   ccos_khz = 9200;
      5'h07:   ccos_khz = 10000;
      5'h08:   ccos_khz = 13000;
      5'h09:   ccos_khz = 15000;
      5'h0a:   ccos_khz = 20000;
      5'h0b:   ccos_khz = 26000;
      5'h0c:   ccos_khz = 32000;
      5'h0d:   ccos_khz = 40000;
      5'h0e:   ccos_khz = 54000;
      5'h0f:   ccos_khz = 80000;
      5'h10:   ccos_khz = 163000;
      default: ccos_khz = 2500;
    endcase
  endfunction : ccos_khz

  // A square wave cannot exceed half the core rate, so faster entries saturate there.
  function automatic logic [ACC_W-1:0] ccos_inc(input logic [SEL_W-1:0] sel);
    longint unsigned v;
    v = (longint'(ccos_khz(sel)) << ACC_W) / longint'(SYS_CLK_KHZ);
    if (v > longint'(INC_LIMIT))
    begin
      v = longint'(INC_LIMIT);
    end
    ccos_inc = v[ACC_W-1:0];
  endfunction : ccos_inc
endpackage : ccos_pkg

// >>> verilog/ccos_gen_if.sv
// Link between the select controller and one clock generator.
interface ccos_gen_if;
  import ccos_pkg::*;
  logic [ACC_W-1:0] inc;
  logic             clk_out;
  logic             wrap;

  modport ctrl
  (
    output inc,
    input  clk_out,
    input  wrap
  );
  modport gen
  (
    input  inc,
    output clk_out,
    output wrap
  );
endinterface : ccos_gen_if

// >>> verilog/ccos_gen.sv
// Phase accumulator clock generator with period-boundary frequency switching.
module ccos_gen
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  ccos_gen_if.gen   gif,
  input  wire logic [ccos_pkg::ACC_W-1:0] inc_reset
);
  import ccos_pkg::*;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] inc_cur;
    logic             out;
    logic             wrap;
    logic             loaded;
  } ccos_gen_state_t;

  ccos_gen_state_t st_reg;
  ccos_gen_state_t st_next;
  logic [ACC_W:0]  sum;

  always_comb
  begin
    st_next = st_reg;
    sum     = {1'b0, st_reg.acc} + {1'b0, st_reg.inc_cur};
    st_next.acc  = sum[ACC_W-1:0];
    st_next.out  = sum[ACC_W-1];
    st_next.wrap = sum[ACC_W];
    // A new rate only takes over at the end of a full period, so no runt pulse appears.
    if (sum[ACC_W])
    begin
      st_next.inc_cur = gif.inc;
    end
    st_next.loaded = 1'b1;
    // The default rate is loaded in the first cycle after reset, not from a reset value.
    if (!st_reg.loaded)
    begin
      st_next.inc_cur = inc_reset;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign gif.clk_out = st_reg.out;
  assign gif.wrap    = st_reg.wrap;
endmodule : ccos_gen

// >>> verilog/ccos_top.sv
// Oscillator and configuration master clock select controller.
module ccos_top
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       cfg_bit_valid,
  input  wire logic                       cfg_bit_data,
  input  wire logic                       cfg_done,
  output logic                            config_master_clock,
  output logic                            osc_clk,
  output logic                            tree_clk,
  output logic                            user_clk_avail,
  output logic                            sel_loaded,
  output logic [ccos_pkg::SEL_W-1:0]      mclk_sel,
  output logic [ccos_pkg::SEL_W-1:0]      osc_sel
);
  import ccos_pkg::*;

  typedef struct packed {
    ccos_phase_t      phase;
    logic [CNT_W-1:0] bit_cnt;
    logic [CFG_BITS-1:0] shift;
    logic [SEL_W-1:0] mclk_sel;
    logic [SEL_W-1:0] osc_sel;
    logic             route_en;
    logic             mclk_out;
    logic             osc_out;
    logic             tree_out;
    logic             avail;
    logic             loaded;
  } ccos_state_t;

  ccos_state_t         st_reg;
  ccos_state_t         st_next;
  logic [CFG_BITS-1:0] word;
  logic [SEL_W-1:0]    new_mclk;
  logic [SEL_W-1:0]    new_osc;

  ccos_gen_if mclk_if ();
  ccos_gen_if osc_if ();

  // Both generators run from the same oscillator core clock from reset onward.
  ccos_gen u_mclk_gen
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .gif       (mclk_if.gen),
    .inc_reset (ccos_inc(SEL_MCLK_DEFAULT))
  );

  ccos_gen u_osc_gen
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .gif       (osc_if.gen),
    .inc_reset (ccos_inc(SEL_OSC_DEFAULT))
  );

  assign mclk_if.inc = ccos_inc(st_reg.mclk_sel);
  assign osc_if.inc  = ccos_inc(st_reg.osc_sel);

  always_comb
  begin
    st_next  = st_reg;
    word     = {st_reg.shift[CFG_BITS-2:0], cfg_bit_data};
    new_mclk = word[FLD_MCLK_LSB +: SEL_W];
    new_osc  = word[FLD_OSC_LSB +: SEL_W];
    st_next.mclk_out = mclk_if.clk_out;
    st_next.osc_out  = osc_if.clk_out;
    st_next.tree_out = osc_if.clk_out & st_reg.route_en;
    case (st_reg.phase)
      PH_DEFAULT, PH_SELECTED:
      begin
        if (cfg_bit_valid)
        begin
          st_next.shift   = word;
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (st_reg.bit_cnt == CNT_LAST)
          begin
            st_next.bit_cnt = CNT_ZERO;
            st_next.phase   = PH_SELECTED;
            // Rates reserved for the oscillator are refused; the master clock keeps its rate.
            if (new_mclk < SEL_OSC_ONLY_LO)
            begin
              st_next.mclk_sel = new_mclk;
            end
            if (new_osc <= SEL_MAX)
            begin
              st_next.osc_sel = new_osc;
            end
            st_next.route_en = word[FLD_ROUTE_BIT];
          end
        end
        if (cfg_done)
        begin
          st_next.phase = PH_USER;
          st_next.avail = 1'b1;
        end
      end
      PH_USER:
      begin
        st_next.avail = 1'b1;
      end
      default:
      begin
        st_next.phase = PH_DEFAULT;
      end
    endcase
    // Kept as a flop so the output follows the phase register without a decode stage.
    st_next.loaded = (st_next.phase != PH_DEFAULT);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg          <= '0;
      st_reg.phase    <= PH_DEFAULT;
      st_reg.mclk_sel <= SEL_MCLK_DEFAULT;
      st_reg.osc_sel  <= SEL_OSC_DEFAULT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign config_master_clock = st_reg.mclk_out;
  assign osc_clk             = st_reg.osc_out;
  assign tree_clk            = st_reg.tree_out;
  assign user_clk_avail      = st_reg.avail;
  assign sel_loaded          = st_reg.loaded;
  assign mclk_sel            = st_reg.mclk_sel;
  assign osc_sel             = st_reg.osc_sel;
endmodule : ccos_top

// >>> test/ccos_top_asserts.sv
// Port-level checks for the oscillator select block.
module ccos_top_asserts
(
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  cfg_bit_valid,
  input wire logic                  cfg_done,
  input wire logic                  config_master_clock,
  input wire logic                  tree_clk,
  input wire logic                  user_clk_avail,
  input wire logic                  sel_loaded,
  input wire logic [ccos_pkg::SEL_W-1:0] mclk_sel,
  input wire logic [ccos_pkg::SEL_W-1:0] osc_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccos_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_default_sel: assert property (
    !sel_loaded |-> mclk_sel == SEL_MCLK_DEFAULT && osc_sel == SEL_OSC_DEFAULT)
    else $error("selection left its default early");
  a_mclk_legal: assert property (mclk_sel < SEL_OSC_ONLY_LO)
    else $error("master clock uses an oscillator-only entry");
  a_osc_legal: assert property (osc_sel <= SEL_MAX)
    else $error("oscillator index outside the table");
  a_sel_cause: assert property (
    $changed(mclk_sel) || $changed(osc_sel) |-> $past(cfg_bit_valid) || $past(cfg_bit_valid, 2))
    else $error("selection changed without configuration bits");
  a_user_freeze: assert property (
    user_clk_avail [*3] |=> $stable(mclk_sel) && $stable(osc_sel))
    else $error("selection changed in user phase");
  a_avail_sticky: assert property (user_clk_avail |=> user_clk_avail)
    else $error("user clock availability dropped");
  a_done_avail: assert property (cfg_done |-> ##[1:2] user_clk_avail)
    else $error("clocks not offered after configuration");
  a_tree_route: assert property (tree_clk |-> sel_loaded)
    else $error("tree clock running without a route choice");
  a_mclk_runs: assert property (!config_master_clock |-> ##[1:8] config_master_clock)
    else $error("master clock stalled low");
endmodule : ccos_top_asserts

bind ccos_top ccos_top_asserts ccos_top_asserts_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .cfg_bit_valid(cfg_bit_valid), .cfg_done(cfg_done), .config_master_clock(config_master_clock),
  .tree_clk(tree_clk), .user_clk_avail(user_clk_avail), .sel_loaded(sel_loaded),
  .mclk_sel(mclk_sel), .osc_sel(osc_sel));

// >>> test/ccos_loader.sv
// Bitstream loader model that shifts clock configuration words in.
module ccos_loader
(
  input wire logic sys_clk,
  output logic     cfg_bit_valid,
  output logic     cfg_bit_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cfg_bit_valid = 1'b0;
  initial cfg_bit_data = 1'b0;
  // Idle data is inverted so a stale bit is never mistaken for a valid one.
  task automatic send(input logic [10:0] w);
    for (int i = 10; i >= 0; i--)
    begin
      @(posedge sys_clk);
      #1 cfg_bit_valid = 1'b1;
      cfg_bit_data = w[i];
    end
    @(posedge sys_clk);
    #1 cfg_bit_valid = 1'b0;
    cfg_bit_data = ~cfg_bit_data;
  endtask : send
endmodule : ccos_loader

// >>> test/config_clock_oscillator_select_test.sv
// Self-checking bench for the oscillator select block.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %0h expected %0h", $time, (a), (b)); end end
module config_clock_oscillator_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ccos_pkg::*;
  logic             sys_clk = 1'b0, rst_b = 1'b0, cfg_done = 1'b0, exp_r = 1'b0, frozen = 1'b0;
  logic             cfg_bit_valid, cfg_bit_data, config_master_clock, osc_clk, tree_clk;
  logic             user_clk_avail, sel_loaded;
  logic [SEL_W-1:0] mclk_sel, osc_sel, exp_m = 5'h01, exp_o = 5'h00;
  int               err_total = 0, n_checks = 0;
  always #50 sys_clk = ~sys_clk;
  ccos_loader ccos_loader_i (.sys_clk(sys_clk), .cfg_bit_valid(cfg_bit_valid),
    .cfg_bit_data(cfg_bit_data));
  ccos_top ccos_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_bit_valid(cfg_bit_valid),
    .cfg_bit_data(cfg_bit_data), .cfg_done(cfg_done), .config_master_clock(config_master_clock),
    .osc_clk(osc_clk), .tree_clk(tree_clk), .user_clk_avail(user_clk_avail),
    .sel_loaded(sel_loaded), .mclk_sel(mclk_sel), .osc_sel(osc_sel));
  // Rising edges in 1000 cycles; the 10 MHz core caps any wave at 5 MHz.
  function automatic int rises(input logic [SEL_W-1:0] s);
    int khz [17] = '{2500, 3100, 4300, 5400, 6900, 8100, 9200, 10000, 13000, 15000,
      20000, 26000, 32000, 40000, 54000, 80000, 163000};
    rises = (khz[s] >= 5000) ? 500 : khz[s] / 10;
  endfunction : rises
  task automatic check_rates();
    int m, o, t, e;
    logic pm, po, pt;
    {m, o, t} = '0;
    repeat (30) @(posedge sys_clk);
    {pm, po, pt} = 3'b111;
    repeat (1000)
    begin
      @(posedge sys_clk);
      #2 m += int'(config_master_clock & ~pm);
      o += int'(osc_clk & ~po);
      t += int'(tree_clk & ~pt);
      {pm, po, pt} = {config_master_clock, osc_clk, tree_clk};
    end
    e = exp_r ? rises(exp_o) : 0;
    `CHK(m inside {[rises(exp_m) - 2 : rises(exp_m) + 2]}, 1'b1)
    `CHK(o inside {[rises(exp_o) - 2 : rises(exp_o) + 2]}, 1'b1)
    `CHK(t inside {[e - 2 : e + 2]}, 1'b1)
  endtask : check_rates
  task automatic load(input logic [4:0] m, input logic [4:0] o, input logic r);
    ccos_loader_i.send({r, o, m});
    if (!frozen)
    begin
      if (m < SEL_OSC_ONLY_LO) exp_m = m;
      if (o <= SEL_MAX) exp_o = o;
      exp_r = r;
    end
    @(posedge sys_clk);
    #2 `CHK(mclk_sel, exp_m)
    `CHK(osc_sel, exp_o)
    `CHK(sel_loaded, 1'b1)
    check_rates();
  endtask : load
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // Watchdog: a hang ends the run as a mismatch.
  initial
  begin
    #5ms err_total++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'h72cb1a5f));
    repeat (6) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    `CHK(mclk_sel, SEL_MCLK_DEFAULT)
    `CHK(osc_sel, SEL_OSC_DEFAULT)
    `CHK(sel_loaded, 1'b0)
    check_rates();
    load(5'h0f, 5'h1f, 1'b1);
    load(5'h10, 5'h10, 1'b0);
    repeat (3) load(5'($urandom_range(14)), 5'($urandom_range(16)), 1'($urandom_range(1)));
    load(5'h0e, 5'h07, 1'b1);
    @(posedge sys_clk);
    #1 cfg_done = 1'b1;
    @(posedge sys_clk);
    #1 cfg_done = 1'b0;
    frozen = 1'b1;
    load(5'h02, 5'h03, 1'b0);
    `CHK(user_clk_avail, 1'b1)
    finish_test();
  end
endmodule : config_clock_oscillator_select_test
